// file: logic/amc_pkg.sv
// Purpose: shared constants and types of the mode configuration port
// Assumes: 125 MHz system clock, synchronous active-high reset
// Notes: register offsets are register indices on the serial link
package amc_pkg;
    localparam int WORD_BITS = 16;
    localparam int ADDR_BITS = 7;
    localparam int DATA_BITS = 8;
    localparam logic [6:0] SOFT_RESET_CONTROL_ADDR = 7'h00;
    localparam logic [6:0] POWER_DOWN_ADDR = 7'h01;
    localparam logic [6:0] TIMING_ADDR = 7'h02;
    localparam logic [6:0] OUTPUT_ADDR = 7'h03;
    localparam logic [6:0] FORMAT_ADDR = 7'h04;
    localparam int RESET_BIT = 7;
    localparam int SLEEP_BIT = 3;
    localparam int DCS_BIT = 0;
    localparam int CURRENT_BIT = 0;
    localparam logic [7:0] MODE_RESET = 8'h00;
    // synchroniser reset value: cs_n idles high, so reset opens no false frame
    localparam logic [3:0] PINS_IDLE = 4'h4;
    localparam logic [4:0] ADDR_DONE_COUNT = 5'h07;
    localparam logic [4:0] WORD_DONE_COUNT = 5'h0F;
    localparam logic [4:0] FIRST_SHIFT_COUNT = 5'h09;
    localparam logic [4:0] LAST_SHIFT_COUNT = 5'h0F;

    typedef struct packed {
        logic [7:0] power_down;
        logic [7:0] timing;
        logic [7:0] output_ctl;
        logic [7:0] format;
    } amc_modes_t;

    typedef struct packed {
        logic interface_select;
        logic cs_n;
        logic sck;
        logic sdi;
    } amc_pins_t;
endpackage

// file: logic/amc_sync.sv
// Purpose: two-stage synchroniser for pins from outside the clock domain
// Assumes: inputs are slow compared with the clock
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module amc_sync #(
    parameter int WIDTH = 4,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clock) begin
        if (reset) begin
            meta <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule
`default_nettype wire

// file: logic/amc_config_port.sv
// Purpose: mode configuration port, parallel straps or four-wire serial
// Assumes: serial clock well below the system clock (125 ns bench period)
// Notes: pins pass through amc_sync; all outputs are flip-flops
`timescale 1ns/1ps
`default_nettype none
module amc_config_port
    import amc_pkg::*;
(
    input wire logic clock,
    input wire logic reset,
    input wire logic interface_select,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic sdi,
    output logic sdo_out,
    output logic sdo_oe,
    output logic dcs_on,
    output logic sleep_on,
    output logic lvds_half_current,
    output amc_modes_t modes
);
    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_HOLD} amc_state_t;

    amc_pins_t pins_raw;
    amc_pins_t pins;
    amc_state_t state;
    logic sck_d;
    logic [4:0] count;
    logic [14:0] shreg;
    logic [7:0] rd_data;
    logic reading;
    logic reset_trig;
    logic sck_rise;
    logic sck_fall;
    logic cs_active;
    logic word_done;
    logic addr_done;
    logic [15:0] next_word;
    logic wr_en;
    logic [7:0] next_rd;

    assign pins_raw = '{interface_select: interface_select, cs_n: cs_n, sck: sck, sdi: sdi};

    amc_sync #(.WIDTH(4), .RESET_VALUE(PINS_IDLE)) u_sync (
        .clock(clock),
        .reset(reset),
        .async_in(pins_raw),
        .sync_out(pins)
    );

    // serial port only when interface select is grounded
    assign cs_active = !pins.interface_select && !pins.cs_n;
    assign sck_rise = pins.sck && !sck_d;
    assign sck_fall = !pins.sck && sck_d;
    assign next_word = {shreg, pins.sdi};
    assign addr_done = cs_active && sck_rise && state == ST_SHIFT && count == ADDR_DONE_COUNT;
    assign word_done = cs_active && sck_rise && state == ST_SHIFT && count == WORD_DONE_COUNT;
    // flag first, seven address bits, eight data bits
    assign wr_en = word_done && !next_word[15];

    // register 00h reads as zero: it is write-only
    always_comb begin
        unique case (next_word[6:0])
            POWER_DOWN_ADDR: next_rd = modes.power_down;
            TIMING_ADDR: next_rd = modes.timing;
            OUTPUT_ADDR: next_rd = modes.output_ctl;
            FORMAT_ADDR: next_rd = modes.format;
            default: next_rd = MODE_RESET;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            sck_d <= 1'b0;
        end else begin
            sck_d <= pins.sck;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state <= ST_IDLE;
            count <= 5'h00;
            shreg <= 15'h0000;
        end else if (!cs_active) begin
            state <= ST_IDLE;
            count <= 5'h00;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    state <= ST_SHIFT;
                    count <= 5'h00;
                    // an edge in the select cycle itself still counts
                    if (sck_rise) begin
                        shreg <= next_word[14:0];
                        count <= 5'h01;
                    end
                end
                ST_SHIFT: begin
                    if (sck_rise) begin
                        shreg <= next_word[14:0];
                        count <= count + 5'h01;
                        if (count == WORD_DONE_COUNT) begin
                            state <= ST_HOLD;
                        end
                    end
                end
                ST_HOLD: begin
                    state <= ST_HOLD;
                end
            endcase
        end
    end

    // read shifter: D7 appears after edge eight, moves on falling edges
    always_ff @(posedge clock) begin
        if (reset) begin
            reading <= 1'b0;
            rd_data <= 8'hFF;
            sdo_oe <= 1'b0;
        end else if (!cs_active) begin
            reading <= 1'b0;
            rd_data <= 8'hFF;
            sdo_oe <= 1'b0;
        end else if (addr_done) begin
            reading <= next_word[7];
            rd_data <= next_word[7] ? next_rd : 8'hFF;
            sdo_oe <= next_word[7] && !next_rd[7];
        end else if (reading && sck_fall && count >= FIRST_SHIFT_COUNT
                     && count <= LAST_SHIFT_COUNT) begin
            rd_data <= {rd_data[6:0], 1'b1};
            sdo_oe <= !rd_data[6];
        end
    end

    // the pin never drives high; the pull-up gives the one
    always_ff @(posedge clock) begin
        if (reset) begin
            sdo_out <= 1'b0;
        end else begin
            sdo_out <= 1'b0;
        end
    end

    // trigger lives one cycle, then clears with the registers
    always_ff @(posedge clock) begin
        if (reset) begin
            reset_trig <= 1'b0;
        end else if (reset_trig) begin
            reset_trig <= 1'b0;
        end else if (wr_en && next_word[14:8] == SOFT_RESET_CONTROL_ADDR) begin
            reset_trig <= next_word[RESET_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (reset || reset_trig) begin
            modes <= '{MODE_RESET, MODE_RESET, MODE_RESET, MODE_RESET};
        end else if (wr_en) begin
            unique case (next_word[14:8])
                POWER_DOWN_ADDR: modes.power_down <= next_word[7:0];
                TIMING_ADDR: modes.timing <= next_word[7:0];
                OUTPUT_ADDR: modes.output_ctl <= next_word[7:0];
                FORMAT_ADDR: modes.format <= next_word[7:0];
                default: modes <= modes;
            endcase
        end
    end

    // straps are followed live; serial mode takes the register fields
    always_ff @(posedge clock) begin
        if (reset) begin
            dcs_on <= 1'b0;
            sleep_on <= 1'b0;
            lvds_half_current <= 1'b0;
        end else if (pins.interface_select) begin
            dcs_on <= pins.cs_n;
            sleep_on <= pins.sck;
            lvds_half_current <= pins.sdi;
        end else begin
            dcs_on <= modes.timing[DCS_BIT];
            sleep_on <= modes.power_down[SLEEP_BIT];
            lvds_half_current <= modes.output_ctl[CURRENT_BIT];
        end
    end

    sequence s_write_word;
        wr_en && next_word[14:8] == TIMING_ADDR;
    endsequence

    sequence s_soft_reset;
        wr_en && next_word[14:8] == SOFT_RESET_CONTROL_ADDR && next_word[RESET_BIT];
    endsequence

    chk_par_dcs: assert property (@(posedge clock) disable iff (reset)
        pins.interface_select |=> dcs_on == $past(pins.cs_n))
        else $error("duty stabilizer does not follow chip select strap");
    chk_par_sleep: assert property (@(posedge clock) disable iff (reset)
        pins.interface_select |=> sleep_on == $past(pins.sck))
        else $error("sleep does not follow clock strap");
    chk_par_current: assert property (@(posedge clock) disable iff (reset)
        pins.interface_select |=> lvds_half_current == $past(pins.sdi))
        else $error("drive current does not follow data strap");
    chk_write_lands: assert property (@(posedge clock) disable iff (reset)
        s_write_word |=> modes.timing == $past(next_word[7:0]))
        else $error("written byte not stored");
    chk_soft_clear: assert property (@(posedge clock) disable iff (reset)
        s_soft_reset |=> reset_trig ##1 (modes == '0 && !reset_trig))
        else $error("software reset did not clear registers");
    chk_trig_pulse: assert property (@(posedge clock) disable iff (reset)
        reset_trig |=> !reset_trig)
        else $error("reset trigger did not clear itself");
    chk_read_keeps: assert property (@(posedge clock) disable iff (reset)
        (word_done && next_word[15]) |=> $stable(modes))
        else $error("read changed a register");
    chk_release_cs: assert property (@(posedge clock) disable iff (reset)
        !cs_active |=> !sdo_oe && !reading)
        else $error("data output not released after deselect");
    chk_never_high: assert property (@(posedge clock) disable iff (reset)
        sdo_out == 1'b0 && (!sdo_oe || reading))
        else $error("data output driven high or pulled low outside a read");
    chk_ignore_extra: assert property (@(posedge clock) disable iff (reset)
        (state == ST_HOLD && cs_active) |=> $stable(shreg) && count == 5'h10)
        else $error("edge after sixteen was taken");
    chk_rd_d7: assert property (@(posedge clock) disable iff (reset)
        (addr_done && next_word[7]) |=> sdo_oe == !$past(next_rd[7]))
        else $error("first read bit wrong");
endmodule
`default_nettype wire

// file: bench/amc_host_model.sv
// Purpose: host model driving the strap and serial pins
// Assumes: 125 ns serial clock, pull-up on the data output line
// Notes: sck stands low and sdi toggles outside frames
`timescale 1ns/1ps
`default_nettype none
module amc_host_model (
    input wire logic sdo_out,
    input wire logic sdo_oe,
    output logic cs_n,
    output logic sck,
    output logic sdi
);
    // pull-up wins unless the device pulls low
    wire logic line = (sdo_oe && !sdo_out) ? 1'b0 : 1'b1;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end
    task automatic strap(input logic c, input logic s, input logic d);
        cs_n = c;
        sck = s;
        sdi = d;
    endtask
    task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
        rd = 8'h00;
        sck = 1'b0;
        cs_n = 1'b0;
        #62.5;
        for (int i = 0; i < n; i++) begin
            // past sixteen bits sdi keeps toggling, so a late sample shows
            sdi = (i < 16) ? w[15 - i] : ~sdi;
            #31.25;
            sck = 1'b1;
            if (i >= 8 && i < 16) begin
                rd = {rd[6:0], line};
            end
            #62.5;
            sck = 1'b0;
            #31.25;
        end
        cs_n = 1'b1;
        sdi = ~sdi;
        #500;
    endtask
endmodule
`default_nettype wire

// file: bench/adc_mode_config_port_test.sv
// Purpose: self-checking bench of the mode configuration port
// Assumes: 8 ns clock, host model on the serial pins
// Notes: each scenario is its own task
`timescale 1ns/1ps
`default_nettype none
module adc_mode_config_port_test;
    import amc_pkg::*;
    logic clock;
    logic reset;
    logic interface_select;
    logic [7:0] rd;
    wire logic cs_n, sck, sdi, sdo_out, sdo_oe, dcs_on, sleep_on, lvds_half_current;
    wire amc_modes_t modes;
    int err_total = 0;
    int checks_done = 0;
    amc_config_port uut (.clock(clock), .reset(reset), .interface_select(interface_select),
        .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
        .dcs_on(dcs_on), .sleep_on(sleep_on), .lvds_half_current(lvds_half_current),
        .modes(modes));
    amc_host_model host (.sdo_out(sdo_out), .sdo_oe(sdo_oe), .cs_n(cs_n), .sck(sck),
        .sdi(sdi));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.xfer({1'b0, a, d}, 16, rd);
    endtask
    task automatic test_straps();
        for (int k = 0; k < 8; k++) begin
            @(negedge clock);
            host.strap(k[2], k[1], k[0]);
            repeat (6) @(negedge clock);
            check(32'(dcs_on), 32'(k[2]), "duty stabilizer");
            check(32'(sleep_on), 32'(k[1]), "sleep");
            check(32'(lvds_half_current), 32'(k[0]), "drive current");
        end
        $display("test straps done");
    endtask
    task automatic test_write();
        @(negedge clock);
        host.strap(1'b1, 1'b0, 1'b0);
        interface_select = 1'b0;
        repeat (8) @(negedge clock);
        wr(7'h00, 8'h80);
        wr(7'h01, 8'h08);
        wr(7'h02, 8'h01);
        wr(7'h03, 8'h01);
        wr(7'h04, 8'hA5);
        check(modes, 32'h0801_01A5, "modes after writes");
        check(32'({dcs_on, sleep_on, lvds_half_current}), 32'h0000_0007, "serial map");
        $display("test write done");
    endtask
    task automatic test_read();
        logic [7:0] ev [5] = '{8'h00, 8'h08, 8'h01, 8'h01, 8'hA5};
        for (int a = 0; a < 5; a++) begin
            // nonzero data bits on a read must not land
            host.xfer({1'b1, 7'(a), 8'h3C}, 16, rd);
            check(32'(rd), 32'(ev[a]), "read back");
            check(32'(sdo_oe), 32'h0000_0000, "line released");
        end
        check(modes, 32'h0801_01A5, "modes after reads");
        $display("test read done");
    endtask
    task automatic test_edges();
        host.xfer({1'b0, 7'h04, 8'h5A}, 20, rd);
        check(modes, 32'h0801_015A, "extra clocks");
        host.xfer({1'b0, 7'h01, 8'hFF}, 12, rd);
        check(modes, 32'h0801_015A, "aborted word");
        wr(7'h05, 8'hFF);
        check(modes, 32'h0801_015A, "unmapped write");
        $display("test edges done");
    endtask
    task automatic test_soft_reset();
        wr(7'h00, 8'h80);
        check(modes, 32'h0000_0000, "soft reset");
        check(32'({dcs_on, sleep_on, lvds_half_current}), 32'h0000_0000, "outputs");
        wr(7'h04, 8'h11);
        check(modes, 32'h0000_0011, "write after reset");
        $display("test soft reset done");
    endtask
    initial begin
        reset = 1'b1;
        interface_select = 1'b1;
        repeat (16) @(negedge clock);
        reset = 1'b0;
        repeat (4) @(negedge clock);
        test_straps();
        test_write();
        test_read();
        test_edges();
        test_soft_reset();
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        conclude();
    end
endmodule
`default_nettype wire
